// [src/exec_pkg.sv]
// Constants and types shared by the execute block
package exec_pkg;
	// ==========================================
	// APB register byte offsets
	localparam logic [7:0] instr_off = 8'h00;
	localparam logic [7:0] operand_off = 8'h04;
	localparam logic [7:0] addr_off = 8'h08;
	localparam logic [7:0] flags_off = 8'h0c;
	localparam logic [7:0] result_off = 8'h10;
	localparam logic [7:0] status_off = 8'h14;
	localparam logic [7:0] creg_base = 8'h20;
	localparam logic [7:0] gpr_base = 8'h40;
	localparam logic [7:0] span_mask = 8'he0;

	// ==========================================
	// Instruction register fields
	localparam int op_lsb = 0;
	localparam int reg_lsb = 8;
	localparam int mem_bit = 11;
	localparam int word_bit = 12;

	// ==========================================
	// Operation bytes and the control register store pattern
	localparam logic [7:0] logical_shift_right_op = 8'h1b;
	localparam logic [7:0] power_down_op = 8'h1a;
	localparam logic [4:0] store_control_reg_op = 5'h13;

	// ==========================================
	// Flag positions in the flags register
	localparam int flag_c = 0;
	localparam int flag_v = 1;
	localparam int flag_z = 2;
	localparam int flag_n = 3;

	// ==========================================
	// Status register bit positions
	localparam int st_busy = 0;
	localparam int st_power_down = 1;
	localparam int st_illegal = 2;
	localparam int st_mem_dest = 3;
	localparam int st_word = 4;

	// ==========================================
	// Reset values
	localparam logic [15:0] reset_word = 16'h0000;
	localparam logic [3:0] reset_flags = 4'h0;
	localparam logic [12:0] reset_instr = 13'h0000;

	// Only control register 0 is word sized; the others are byte wide
	localparam logic [7:0] creg_word_map = 8'h01;

	typedef enum logic [1:0] {
		st_idle,
		st_exec,
		st_sleep,
		st_except
	} exec_state_t;
endpackage : exec_pkg

// [src/gpr_file.sv]
// Eight 16-bit general registers with one byte-lane write port
`timescale 1ns/1ns
module gpr_file
	import exec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [2:0] wr_idx,
	input wire logic wr_word,
	input wire logic [15:0] wr_data,
	input wire logic [2:0] rd_a_idx,
	output logic [15:0] rd_a_data,
	input wire logic [2:0] rd_b_idx,
	output logic [15:0] rd_b_data
);
	// ==========================================
	// Storage
	logic [15:0] gpr_r [8];

	// A byte write keeps the upper half of the register intact
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				gpr_r[i] <= reset_word;
			end
		end else if (wr_en) begin
			gpr_r[wr_idx][7:0] <= wr_data[7:0];
			if (wr_word) begin
				gpr_r[wr_idx][15:8] <= wr_data[15:8];
			end
		end
	end

	assign rd_a_data = gpr_r[rd_a_idx];
	assign rd_b_data = gpr_r[rd_b_idx];
endmodule : gpr_file

// [src/shift_sleep_store_ctrl_exec.sv]
// Execute unit for logical right shift, power-down entry and control register store
// Behaviour
// (RULE1) Shift moves each bit one place right; top result bit becomes zero.
// (RULE2) Carry takes the bit shifted out of the least significant position.
// (RULE3) Shift always clears negative and overflow flags.
// (RULE4) Shift sets zero flag when result is zero, else clears it.
// (RULE5) Shift works on byte or word in register or memory, writes back there.
// (RULE6) Power-down stops fetch and execution, then waits for exception request.
// (RULE7) All CPU state is held unchanged while powered down.
// (RULE8) Exception request ends power-down and starts exception handling at once.
// (RULE9) Power-down leaves all four flags unchanged.
// (RULE10) Control register store copies selected register, size set by that register.
// (RULE11) Control register store leaves all four flags unchanged.
// (RULE12) Shift is operation byte 00011011; power-down is standalone byte 00011010.
`timescale 1ns/1ns
module shift_sleep_store_ctrl_exec
	import exec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic exc_req,
	output logic exc_start,
	output logic power_down,
	output logic fetch_enable,
	output logic mem_wr,
	output logic mem_word,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata
);
	// ==========================================
	// Decode helpers
	function automatic logic is_shift(input logic [7:0] op);
		return op == logical_shift_right_op;
	endfunction : is_shift

	function automatic logic is_store_cr(input logic [7:0] op);
		return op[7:3] == store_control_reg_op;
	endfunction : is_store_cr

	function automatic logic is_sleep(input logic [7:0] op);
		return op == power_down_op;
	endfunction : is_sleep

	function automatic logic [15:0] size_mask(input logic word);
		return word ? 16'hffff : 16'h00ff;
	endfunction : size_mask

	// ==========================================
	// State
	exec_state_t state_r;
	exec_state_t state_nxt;
	logic [12:0] instr_r;
	logic [15:0] operand_r;
	logic [15:0] addr_r;
	logic [3:0] flags_r;
	logic [15:0] result_r;
	logic illegal_r;
	logic res_mem_r;
	logic res_word_r;
	logic [15:0] creg_r [8];
	logic mem_wr_r;
	logic mem_word_r;
	logic [15:0] mem_addr_r;
	logic [15:0] mem_wdata_r;
	logic exc_start_r;

	// ==========================================
	// Instruction field views
	logic [7:0] op;
	logic [2:0] rn;
	logic dst_mem;
	logic op_word;
	logic [2:0] cr_idx;
	logic cr_word;

	assign op = instr_r[op_lsb +: 8];
	assign rn = instr_r[reg_lsb +: 3];
	assign dst_mem = instr_r[mem_bit];
	assign op_word = instr_r[word_bit];
	assign cr_idx = op[2:0];
	assign cr_word = creg_word_map[cr_idx];

	// ==========================================
	// APB decode
	logic access;
	logic wr_acc;
	logic rd_acc;
	logic hit_gpr;
	logic hit_creg;
	logic hit_fixed;
	logic mapped;
	logic [2:0] win_idx;
	logic gpr_busy;

	assign access = psel && penable;
	assign hit_gpr = (paddr & span_mask) == gpr_base;
	assign hit_creg = (paddr & span_mask) == creg_base;
	assign win_idx = paddr[4:2];
	assign hit_fixed = paddr == instr_off || paddr == operand_off || paddr == addr_off
		|| paddr == flags_off || paddr == result_off || paddr == status_off;
	assign mapped = (hit_gpr || hit_creg || hit_fixed) && paddr[1:0] == 2'b00;

	// ==========================================
	// General register file
	logic ex_gpr_wr;
	logic [15:0] dst_reg_val;
	logic [15:0] apb_gpr_val;
	logic apb_gpr_wr;
	logic gpr_wr_en;
	logic [2:0] gpr_wr_idx;
	logic gpr_wr_word;
	logic [15:0] gpr_wr_data;
	logic [15:0] ex_wdata;

	// An APB write to a general register collides with execute write-back; it waits
	assign gpr_busy = hit_gpr && pwrite && ex_gpr_wr;
	assign pready = !gpr_busy;
	assign wr_acc = access && pready && pwrite && mapped;
	assign rd_acc = access && pready && !pwrite;
	assign pslverr = access && !mapped;

	// Software must not disturb the register file while powered down
	assign apb_gpr_wr = wr_acc && hit_gpr && state_r != st_sleep; // RULE7
	assign gpr_wr_en = ex_gpr_wr || apb_gpr_wr;
	assign gpr_wr_idx = ex_gpr_wr ? rn : win_idx;
	assign gpr_wr_word = ex_gpr_wr ? (is_store_cr(op) ? cr_word : op_word) : 1'b1;
	assign gpr_wr_data = ex_gpr_wr ? ex_wdata : pwdata[15:0];

	gpr_file u_gpr (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(gpr_wr_en),
		.wr_idx(gpr_wr_idx),
		.wr_word(gpr_wr_word),
		.wr_data(gpr_wr_data),
		.rd_a_idx(rn),
		.rd_a_data(dst_reg_val),
		.rd_b_idx(win_idx),
		.rd_b_data(apb_gpr_val)
	);

	// ==========================================
	// Datapath
	logic [15:0] dst_val;
	logic [15:0] shifted;
	logic shift_c;
	logic shift_z;
	logic [15:0] cr_val;
	logic valid_op;
	logic issue;

	assign dst_val = (dst_mem ? operand_r : dst_reg_val) & size_mask(op_word); // RULE5
	// The vacated top bit of the selected size is filled with zero
	assign shifted = {1'b0, dst_val[15:1]}; // RULE1
	assign shift_c = dst_val[0]; // RULE2
	assign shift_z = shifted == 16'h0000; // RULE4
	assign cr_val = creg_r[cr_idx] & size_mask(cr_word); // RULE10
	assign ex_wdata = is_store_cr(op) ? cr_val : shifted;
	assign valid_op = is_shift(op) || is_store_cr(op) || is_sleep(op); // RULE12
	assign ex_gpr_wr = state_r == st_exec && !dst_mem && (is_shift(op) || is_store_cr(op));
	assign issue = wr_acc && paddr == instr_off && state_r == st_idle;

	// ==========================================
	// Sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			st_idle: begin
				if (issue) begin
					state_nxt = st_exec;
				end
			end
			st_exec: begin
				if (is_sleep(op)) begin
					state_nxt = st_sleep; // RULE6
				end else begin
					state_nxt = st_idle;
				end
			end
			st_sleep: begin
				if (exc_req) begin
					state_nxt = st_except; // RULE8
				end
			end
			st_except: begin
				state_nxt = st_idle;
			end
			default: begin
				state_nxt = st_idle;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= st_idle;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================
	// Software-written registers; an instruction write while busy is ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_r <= reset_instr;
		end else if (issue) begin
			instr_r <= pwdata[12:0];
		end
	end

	// Operand and address are frozen while powered down, like all other state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			operand_r <= reset_word;
			addr_r <= reset_word;
		end else if (wr_acc && state_r != st_sleep) begin // RULE7
			if (paddr == operand_off) begin
				operand_r <= pwdata[15:0];
			end
			if (paddr == addr_off) begin
				addr_r <= pwdata[15:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				creg_r[i] <= reset_word;
			end
		end else if (wr_acc && hit_creg && state_r != st_sleep) begin // RULE7
			creg_r[win_idx] <= pwdata[15:0] & size_mask(creg_word_map[win_idx]);
		end
	end

	// ==========================================
	// Flags: of the operations only the shift touches them, so sleep and store leave them alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= reset_flags;
		end else if (state_r == st_exec && is_shift(op)) begin // RULE9 RULE11
			flags_r[flag_n] <= 1'b0; // RULE3
			flags_r[flag_v] <= 1'b0; // RULE3
			flags_r[flag_z] <= shift_z; // RULE4
			flags_r[flag_c] <= shift_c; // RULE2
		end else if (wr_acc && paddr == flags_off && state_r == st_idle) begin
			flags_r <= pwdata[3:0];
		end
	end

	// ==========================================
	// Result capture for status reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_r <= reset_word;
			illegal_r <= 1'b0;
			res_mem_r <= 1'b0;
			res_word_r <= 1'b0;
		end else if (state_r == st_exec) begin
			illegal_r <= !valid_op;
			if (is_shift(op) || is_store_cr(op)) begin
				result_r <= ex_wdata;
				res_mem_r <= dst_mem;
				res_word_r <= is_store_cr(op) ? cr_word : op_word;
			end
		end
	end

	// ==========================================
	// Memory write-back goes to the same address the operand came from
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_wr_r <= 1'b0;
			mem_word_r <= 1'b0;
			mem_addr_r <= reset_word;
			mem_wdata_r <= reset_word;
		end else begin
			mem_wr_r <= state_r == st_exec && dst_mem && (is_shift(op) || is_store_cr(op));
			if (state_r == st_exec && dst_mem) begin
				mem_word_r <= is_store_cr(op) ? cr_word : op_word; // RULE10
				mem_addr_r <= addr_r; // RULE5
				mem_wdata_r <= ex_wdata;
			end
		end
	end

	// ==========================================
	// Exception handling starts in the cycle after the request is seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exc_start_r <= 1'b0;
		end else begin
			exc_start_r <= state_r == st_sleep && exc_req; // RULE8
		end
	end

	assign exc_start = exc_start_r;
	assign power_down = state_r == st_sleep; // RULE6
	assign fetch_enable = state_r == st_idle; // RULE6
	assign mem_wr = mem_wr_r;
	assign mem_word = mem_word_r;
	assign mem_addr = mem_addr_r;
	assign mem_wdata = mem_wdata_r;

	// ==========================================
	// Read data; unmapped fixed addresses read zero, misaligned register window addresses read the register; all raise pslverr
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_acc) begin
			if (hit_gpr) begin
				prdata = {16'h0000, apb_gpr_val};
			end else if (hit_creg) begin
				prdata = {16'h0000, creg_r[win_idx]};
			end else begin
				case (paddr)
					instr_off: prdata = {19'h0_0000, instr_r};
					operand_off: prdata = {16'h0000, operand_r};
					addr_off: prdata = {16'h0000, addr_r};
					flags_off: prdata = {28'h000_0000, flags_r};
					result_off: prdata = {16'h0000, result_r};
					status_off: begin
						prdata[st_busy] = state_r != st_idle;
						prdata[st_power_down] = state_r == st_sleep;
						prdata[st_illegal] = illegal_r;
						prdata[st_mem_dest] = res_mem_r;
						prdata[st_word] = res_word_r;
					end
					default: prdata = 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : shift_sleep_store_ctrl_exec

// [test/exec_sva.sv]
// Port checker for the execute block
`timescale 1ns/1ns
module exec_sva
	import exec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic exc_req,
	input wire logic exc_start,
	input wire logic power_down,
	input wire logic fetch_enable,
	input wire logic mem_wr,
	input wire logic mem_word,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========
	// Assertions
	sleep_nofetch_a: assert property (power_down |-> !fetch_enable)
		else $error("fetch enabled while asleep");
	sleep_hold_a: assert property (power_down && !exc_req |=> power_down)
		else $error("left sleep without request");
	wake_start_a: assert property (power_down && exc_req |=> exc_start && !power_down)
		else $error("request did not start exception handling");
	exc_pulse_a: assert property (exc_start |=> !exc_start)
		else $error("exception start longer than one cycle");
	exc_nofetch_a: assert property (exc_start |-> !fetch_enable)
		else $error("fetch during exception entry");
	mem_pulse_a: assert property (mem_wr |=> !mem_wr)
		else $error("memory write longer than one cycle");
	byte_upper_a: assert property (mem_wr && !mem_word |-> mem_wdata[15:8] == 8'h00)
		else $error("byte write with upper data set");
	mem_awake_a: assert property (mem_wr |-> !power_down)
		else $error("memory write while asleep");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	idle_rdata_a: assert property (!psel |-> prdata == 32'h0000_0000)
		else $error("read data outside access");
	zero_wait_a: assert property (psel && penable && paddr[7:5] != 3'b010 |-> pready)
		else $error("wait state outside register file");
	// Main scenarios
	cover property (exc_start);
	cover property (mem_wr && mem_word);
	cover property ($rose(power_down));
endmodule : exec_sva

bind shift_sleep_store_ctrl_exec exec_sva u_exec_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .exc_req(exc_req),
	.exc_start(exc_start), .power_down(power_down), .fetch_enable(fetch_enable),
	.mem_wr(mem_wr), .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata));

// [test/shift_sleep_store_ctrl_exec_tb.sv]
// Self-checking bench for the execute block
`timescale 1ns/1ns
module shift_sleep_store_ctrl_exec_tb;
	import exec_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, exc_req;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic pready, pslverr, exc_start, power_down, fetch_enable, mem_wr, mem_word, ev;
	logic [15:0] mem_addr, mem_wdata, cap_addr, cap_data;
	logic cap_word;
	int mem_cnt, fail_count, tests_run;
	shift_sleep_store_ctrl_exec u_shift_sleep_store_ctrl_exec (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .exc_req(exc_req),
		.exc_start(exc_start), .power_down(power_down), .fetch_enable(fetch_enable),
		.mem_wr(mem_wr), .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
	initial begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end
	// Memory side seen only through the write-back pulse
	always @(posedge pclk) begin
		if (mem_wr === 1'b1) begin
			cap_addr <= mem_addr;
			cap_data <= mem_wdata;
			cap_word <= mem_word;
			mem_cnt <= mem_cnt + 1;
		end
	end
	// ==========
	// Helpers
	task automatic summarize;
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			chk("pready", 1, pready);
			summarize();
		end
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic issue(input logic [31:0] ins);
		int n;
		apb(1, instr_off, ins);
		n = 0;
		do begin
			apb(0, status_off, 0);
			n++;
		end while (rv[st_busy] !== 1'b0 && n < 20);
		if (rv[st_busy] !== 1'b0) begin
			chk("busy", 0, rv[st_busy]);
			summarize();
		end
	endtask : issue
	// ==========
	// Scenarios
	task automatic t_shift;
		apb(1, gpr_base + 8'h04, 32'h0000_8001);
		apb(1, flags_off, 32'h0000_000a);
		issue(32'h0000_111b);
		apb(0, gpr_base + 8'h04, 0);
		chk("word reg", 32'h0000_4000, rv);
		apb(0, flags_off, 0);
		chk("word flags", 32'h0000_0001, rv);
		apb(1, gpr_base + 8'h08, 32'h0000_1301);
		issue(32'h0000_021b);
		apb(0, gpr_base + 8'h08, 0);
		chk("byte reg", 32'h0000_1300, rv);
		apb(0, flags_off, 0);
		chk("byte flags", 32'h0000_0005, rv);
		apb(1, addr_off, 32'h0000_1234);
		apb(1, operand_off, 32'h0000_0002);
		issue(32'h0000_181b);
		chk("mem count", 1, mem_cnt);
		chk("mem addr", 32'h0000_1234, cap_addr);
		chk("mem data", 32'h0000_0001, cap_data);
		chk("mem word", 1, cap_word);
	endtask : t_shift
	task automatic t_sleep;
		int n;
		apb(1, flags_off, 32'h0000_0005);
		apb(1, operand_off, 32'h0000_00aa);
		apb(1, instr_off, 32'h0000_001a);
		n = 0;
		while (power_down !== 1'b1 && n < 10) begin
			@(posedge pclk);
			n++;
		end
		chk("asleep", 1, power_down);
		if (power_down !== 1'b1)
			summarize();
		chk("fetch off", 0, fetch_enable);
		apb(1, operand_off, 32'h0000_0055);
		apb(0, operand_off, 0);
		chk("operand held", 32'h0000_00aa, rv);
		apb(1, gpr_base + 8'h04, 32'h0000_0077);
		apb(0, gpr_base + 8'h04, 0);
		chk("reg held", 32'h0000_4000, rv);
		apb(0, flags_off, 0);
		chk("sleep flags", 32'h0000_0005, rv);
		exc_req <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (exc_start !== 1'b1 && n < 10);
		chk("exc start", 1, exc_start);
		if (exc_start !== 1'b1)
			summarize();
		chk("awake", 0, power_down);
		exc_req <= 1'b0;
		issue(32'h0000_0000);
		chk("fetch on", 1, fetch_enable);
	endtask : t_sleep
	task automatic t_store;
		apb(1, creg_base, 32'h0000_abcd);
		apb(1, flags_off, 32'h0000_000a);
		issue(32'h0000_0398);
		apb(0, gpr_base + 8'h0c, 0);
		chk("store word", 32'h0000_abcd, rv);
		apb(1, creg_base + 8'h08, 32'h0000_01ff);
		issue(32'h0000_089a);
		chk("store byte", 32'h0000_00ff, cap_data);
		chk("store size", 0, cap_word);
		apb(0, flags_off, 0);
		chk("store flags", 32'h0000_000a, rv);
		issue(32'h0000_011c);
		chk("illegal", 1, rv[st_illegal]);
		apb(0, gpr_base + 8'h04, 0);
		chk("no effect", 32'h0000_4000, rv);
		apb(0, 8'h18, 0);
		chk("unmapped", 1, ev);
	endtask : t_store
	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		exc_req = 0;
		mem_cnt = 0;
		fail_count = 0;
		tests_run = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_shift();
		t_sleep();
		t_store();
		summarize();
	end
endmodule : shift_sleep_store_ctrl_exec_tb
